// File: rtl/jcam_top.sv
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`include "jcam_map.svh"
module jcam_top import jcam_pkg::*; #(
    parameter int BLINK_HALF = `JCAM_BLINK_HALF
) (
    // Clock, reset, enable
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       ce,
    // Configuration jumper header pins
    input  wire logic [15:0] config_jumper_header,
    // Host command bus
    input  wire logic [7:0] cmd_bus,
    input  wire logic       cmd_parity,
    input  wire logic       cmd_strobe,
    // Command decode results
    output logic            cmd_hit,
    output logic [3:0]      cmd_code,
    output logic            parity_err_irq,
    // Disk head select
    input  wire logic [3:0] head_num,
    input  wire logic       write_current_lowering_req,
    output logic [2:0]      head_sel,
    output logic            write_current_lowering,
    // Diagnostics and light
    output logic            diag_run,
    output logic            power_light,
    // Register port
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic [7:0]      reg_rdata
);
    logic [15:0]   jmp_sync;
    jcam_jumpers_t jmp_r;
    logic          jmp_valid_r;
    logic [2:0]    stb_sync_r;
    logic          stb_lvl_r;
    logic          stb_prev_r;
    jcam_cmd_t     cmd_r;
    logic          cmd_par_r;
    logic          stb_rise;
    logic          par_ok;
    logic [7:0]    ctrl_r;
    jcam_diag_t    diag_r;
    jcam_diag_t    diag_nxt;
    logic          blink;
    logic          diag_done_r;
    logic          diag_fail_r;

    jcam_sync #(
        .WIDTH (16)
    ) u_sync (
        .clk      (clk),
        .rst_b    (rst_b),
        .ce       (ce),
        .pin_in   (config_jumper_header),
        .sync_out (jmp_sync)
    );

    // Header pins 1..4 carry address bits 3..0, pins 5..12 the config byte bits 7..0.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            jmp_r       <= '0;
            jmp_valid_r <= 1'b0;
        end else if (ce) begin
            jmp_valid_r         <= 1'b1;
            jmp_r.dev_addr      <= {jmp_sync[0], jmp_sync[1], jmp_sync[2], jmp_sync[3]};
            jmp_r.cfg_byte      <= {jmp_sync[4], jmp_sync[5], jmp_sync[6], jmp_sync[7],
                                    jmp_sync[8], jmp_sync[9], jmp_sync[10], jmp_sync[11]};
            jmp_r.parity_dis    <= jmp_sync[12];
            jmp_r.loopback      <= jmp_sync[13];
            jmp_r.tape          <= jmp_sync[14];
            jmp_r.spare         <= jmp_sync[15];
        end
    end

    // Command bus sampling: the strobe passes three flops and its level moves only
    // once stages two and three agree, so a slow or noisy edge counts once.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            stb_sync_r <= 3'b000;
            stb_lvl_r  <= 1'b0;
            stb_prev_r <= 1'b0;
            cmd_r      <= '0;
            cmd_par_r  <= 1'b0;
        end else if (ce) begin
            stb_sync_r <= {stb_sync_r[1:0], cmd_strobe};
            if (stb_sync_r[1] == stb_sync_r[2]) begin
                stb_lvl_r <= stb_sync_r[2];
            end
            stb_prev_r <= stb_lvl_r;
            cmd_r      <= jcam_cmd_t'(cmd_bus);
            cmd_par_r  <= cmd_parity;
        end
    end

    assign stb_rise = stb_lvl_r & ~stb_prev_r;
    // Odd parity over the command byte and parity line.
    assign par_ok   = ^{cmd_r, cmd_par_r};

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cmd_hit        <= 1'b0;
            cmd_code       <= 4'h0;
            parity_err_irq <= 1'b0;
        end else if (ce) begin
            cmd_hit        <= 1'b0;
            parity_err_irq <= 1'b0;
            if (stb_rise && jmp_valid_r && cmd_r.dev_addr == jmp_r.dev_addr) begin
                if (!jmp_r.parity_dis && !par_ok) begin
                    parity_err_irq <= 1'b1;
                end else begin
                    cmd_hit  <= 1'b1;
                    cmd_code <= cmd_r.cmd_code;
                end
            end
        end
    end

    // Head select with optional fourth bit on the write current lowering line.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            head_sel               <= 3'h0;
            write_current_lowering <= 1'b0;
        end else if (ce) begin
            head_sel <= head_num[2:0];
            write_current_lowering <= ctrl_r[`JCAM_CTL_HS3] ? head_num[3]
                                                            : write_current_lowering_req;
        end
    end

    // Control register; diag start/fail/done bits are one-shot from the microprocessor.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ctrl_r <= `JCAM_CTL_RST;
        end else if (ce) begin
            ctrl_r[7:1] <= 7'h0;
            if (reg_wr && reg_addr == `JCAM_OFF_CTRL) begin
                ctrl_r <= reg_wdata;
            end
        end
    end

    // Diagnostic sequencer: run, wait for result, repeat in loopback.
    always_comb begin
        diag_nxt = diag_r;
        unique case (diag_r)
            JCAM_IDLE: if (ctrl_r[`JCAM_CTL_DIAG_START]) diag_nxt = JCAM_RUN;
            JCAM_RUN:  diag_nxt = JCAM_WAIT;
            JCAM_WAIT: begin
                if (ctrl_r[`JCAM_CTL_DIAG_FAIL]) begin
                    diag_nxt = JCAM_FAIL;
                end else if (ctrl_r[`JCAM_CTL_DIAG_DONE]) begin
                    diag_nxt = jmp_r.loopback ? JCAM_RUN : JCAM_IDLE;
                end
            end
            JCAM_FAIL: diag_nxt = JCAM_FAIL;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            diag_r      <= JCAM_IDLE;
            diag_run    <= 1'b0;
            diag_done_r <= 1'b0;
            diag_fail_r <= 1'b0;
        end else if (ce) begin
            diag_r   <= diag_nxt;
            diag_run <= (diag_nxt == JCAM_RUN);
            if (diag_r == JCAM_WAIT && ctrl_r[`JCAM_CTL_DIAG_DONE]) begin
                diag_done_r <= 1'b1;
            end
            diag_fail_r <= (diag_nxt == JCAM_FAIL);
        end
    end

    jcam_blink #(
        .HALF (BLINK_HALF)
    ) u_blink (
        .clk    (clk),
        .rst_b  (rst_b),
        .ce     (ce),
        .enable (jmp_r.loopback && diag_r != JCAM_IDLE && diag_r != JCAM_FAIL),
        .blink  (blink)
    );

    // Light: blinks in loopback while the diagnostic is not idle, off after failure, steady on otherwise.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            power_light <= 1'b0;
        end else if (ce) begin
            if (diag_r == JCAM_FAIL) begin
                power_light <= 1'b0;
            end else if (jmp_r.loopback && diag_r != JCAM_IDLE) begin
                power_light <= blink;
            end else begin
                power_light <= 1'b1;
            end
        end
    end

    // Register read port: data in the cycle after the read strobe.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            reg_rdata <= 8'h00;
        end else if (ce) begin
            reg_rdata <= 8'h00;
            if (reg_rd) begin
                unique case (reg_addr)
                    `JCAM_OFF_CFG_BYTE: reg_rdata <= jmp_r.cfg_byte;
                    `JCAM_OFF_FLAGS:    reg_rdata <= {4'h0, jmp_r.spare, jmp_r.tape,
                                                      jmp_r.loopback, ~jmp_r.parity_dis};
                    `JCAM_OFF_ADDR:     reg_rdata <= {4'h0, jmp_r.dev_addr};
                    `JCAM_OFF_CTRL:     reg_rdata <= {7'h0, ctrl_r[`JCAM_CTL_HS3]};
                    `JCAM_OFF_QUERY3:   reg_rdata <= {6'h0, jmp_r.spare, jmp_r.tape};
                    `JCAM_OFF_STATUS:   reg_rdata <= {4'h0, diag_fail_r, diag_done_r, diag_r};
                    default:            reg_rdata <= 8'h00;
                endcase
            end
        end
    end
endmodule

// File: rtl/jcam_map.svh
`ifndef JCAM_MAP_SVH
`define JCAM_MAP_SVH

// Register offsets on the local microprocessor port.
`define JCAM_OFF_CFG_BYTE     4'h0
`define JCAM_OFF_FLAGS        4'h1
`define JCAM_OFF_ADDR         4'h2
`define JCAM_OFF_CTRL         4'h3
`define JCAM_OFF_QUERY3       4'h4
`define JCAM_OFF_STATUS       4'h5

// Field positions.
`define JCAM_FLG_PARITY_EN    0
`define JCAM_FLG_LOOPBACK     1
`define JCAM_FLG_TAPE         2
`define JCAM_FLG_SPARE        3
`define JCAM_Q3_TAPE          0
`define JCAM_Q3_SPARE         1
`define JCAM_CTL_HS3          0
`define JCAM_CTL_DIAG_START   1
`define JCAM_CTL_DIAG_FAIL    2
`define JCAM_CTL_DIAG_DONE    3
`define JCAM_CTL_RST          8'h00
`define JCAM_DRIVE_NONE       4'h0

// Light timing at 250 MHz: half of a 1 Hz period.
`define JCAM_CLK_HZ           250000000
`define JCAM_BLINK_HZ         1
`define JCAM_BLINK_HALF       (`JCAM_CLK_HZ / (2 * `JCAM_BLINK_HZ))

`endif

// File: rtl/jcam_pkg.sv
package jcam_pkg;

    typedef struct packed {
        logic       spare;
        logic       tape;
        logic       loopback;
        logic       parity_dis;
        logic [7:0] cfg_byte;
        logic [3:0] dev_addr;
    } jcam_jumpers_t;

    typedef struct packed {
        logic [3:0] cmd_code;
        logic [3:0] dev_addr;
    } jcam_cmd_t;

    typedef enum logic [1:0] {
        JCAM_IDLE = 2'b00,
        JCAM_RUN  = 2'b01,
        JCAM_WAIT = 2'b11,
        JCAM_FAIL = 2'b10
    } jcam_diag_t;

endpackage

// File: rtl/jcam_sync.sv
`timescale 1ns/1ps
// Three-stage pin synchroniser; the output changes once stages two and three agree.
module jcam_sync import jcam_pkg::*; #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic             ce,
    // Data
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s1_r     <= '0;
            s2_r     <= '0;
            s3_r     <= '0;
            sync_out <= '0;
        end else if (ce) begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            for (int i = 0; i < WIDTH; i++) begin
                if (s2_r[i] == s3_r[i]) begin
                    sync_out[i] <= s3_r[i];
                end
            end
        end
    end
endmodule

// File: rtl/jcam_blink.sv
`timescale 1ns/1ps
`include "jcam_map.svh"
// Toggles its output every half period while enabled; holds low otherwise.
module jcam_blink import jcam_pkg::*; #(
    parameter int HALF = `JCAM_BLINK_HALF
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic ce,
    // Control
    input  wire logic enable,
    output logic      blink
);
    logic [31:0] cnt_r;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cnt_r <= 32'h0;
            blink <= 1'b0;
        end else if (ce) begin
            if (!enable) begin
                cnt_r <= 32'h0;
                blink <= 1'b0;
            end else if (cnt_r >= 32'(HALF - 1)) begin
                cnt_r <= 32'h0;
                blink <= ~blink;
            end else begin
                cnt_r <= cnt_r + 32'h1;
            end
        end
    end
endmodule

// File: sim/jcam_monitor.sv
`timescale 1ns/1ps
module jcam_mon import jcam_pkg::*; (
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst_b,
    // Watched pins
    input wire logic [15:0] config_jumper_header,
    input wire logic [7:0]  cmd_bus,
    input wire logic        cmd_parity,
    input wire logic        cmd_strobe,
    input wire logic        cmd_hit,
    input wire logic [3:0]  cmd_code,
    input wire logic        parity_err_irq,
    input wire logic [3:0]  head_num,
    input wire logic [2:0]  head_sel,
    input wire logic        diag_run,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata
);
    logic [3:0] adr;
    logic       me;
    logic       par_ok;
    assign adr    = {<<{config_jumper_header[3:0]}};
    assign me     = cmd_bus[3:0] == adr;
    assign par_ok = config_jumper_header[12] | ^{cmd_bus, cmd_parity};
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside read slot");
    a_head_sel_follow: assert property ($past(rst_b, 2) |-> head_sel == $past(head_num[2:0]))
        else $error("head select mismatch");
    a_hit_irq_excl: assert property (!(cmd_hit && parity_err_irq))
        else $error("hit and parity error together");
    a_hit_one_cycle: assert property (cmd_hit |=> !cmd_hit)
        else $error("hit longer than one cycle");
    a_hit_addr_code: assert property (cmd_hit |-> me && cmd_code == cmd_bus[7:4])
        else $error("hit on wrong address or code");
    a_good_cmd_hit: assert property ($rose(cmd_strobe) && me && par_ok |-> ##[2:5] cmd_hit)
        else $error("addressed command not taken");
    a_bad_par_irq: assert property ($rose(cmd_strobe) && me && !par_ok |-> ##[2:5] parity_err_irq)
        else $error("parity error not flagged");
    a_other_addr_quiet: assert property ($rose(cmd_strobe) && !me |-> !(cmd_hit || parity_err_irq) [*6])
        else $error("answer to foreign address");
    c_hit: cover property (cmd_hit);
    c_par_err: cover property (parity_err_irq);
    c_diag_again: cover property (diag_run ##[1:40] diag_run);
endmodule

bind jcam_top jcam_mon jcam_mon_i (.*);

// File: sim/jcam_host.sv
`timescale 1ns/1ps
module jcam_host import jcam_pkg::*; (
    // Clock
    input wire logic  clk,
    // Command bus toward the block
    output jcam_cmd_t cmd_bus,
    output logic      cmd_parity,
    output logic      cmd_strobe
);
    initial begin
        cmd_bus    = 8'h00;
        cmd_parity = 1'b1;
        cmd_strobe = 1'b0;
    end
    // Sets up the byte, strobes it, then lets the lines float to the inverse.
    task automatic send(input jcam_cmd_t c, input logic bad, input int setup);
        cmd_bus    <= c;
        cmd_parity <= ~^c ^ bad;
        repeat (setup) @(posedge clk);
        cmd_strobe <= 1'b1;
        repeat (6) @(posedge clk);
        cmd_strobe <= 1'b0;
        @(posedge clk);
        cmd_bus    <= ~c;
        cmd_parity <= ^c ^ bad;
        repeat (3) @(posedge clk);
    endtask
endmodule

// File: sim/jcam_top_tb.sv
`timescale 1ns/1ps
module jcam_top_tb;
    logic        clk = 1'b0, rst_b = 1'b0, wcl_req = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [15:0] hdr = 16'h5a3b;
    logic [3:0]  head_num = 4'h0, reg_addr = 4'h0;
    logic [7:0]  reg_wdata = 8'h00;
    logic [7:0]  cmd_bus, reg_rdata, rdv;
    logic        cmd_parity, cmd_strobe, cmd_hit, parity_err_irq, wcl, diag_run, power_light;
    logic [3:0]  cmd_code;
    logic [2:0]  head_sel;
    int          failures = 0, cmp_count = 0, hits = 0, irqs = 0, diags = 0;

    always #2 clk = ~clk;

    jcam_top #(.BLINK_HALF(4)) jcam_top_i (
        .clk(clk), .rst_b(rst_b), .ce(1'b1), .config_jumper_header(hdr),
        .cmd_bus(cmd_bus), .cmd_parity(cmd_parity), .cmd_strobe(cmd_strobe),
        .cmd_hit(cmd_hit), .cmd_code(cmd_code), .parity_err_irq(parity_err_irq),
        .head_num(head_num), .write_current_lowering_req(wcl_req), .head_sel(head_sel),
        .write_current_lowering(wcl), .diag_run(diag_run), .power_light(power_light),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    jcam_host jcam_host_i (.clk(clk), .cmd_bus(cmd_bus), .cmd_parity(cmd_parity), .cmd_strobe(cmd_strobe));

    always @(posedge clk) begin
        hits  = hits + int'(cmd_hit === 1'b1);
        irqs  = irqs + int'(parity_err_irq === 1'b1);
        diags = diags + int'(diag_run === 1'b1);
    end

    task automatic complete_run;
        if (failures == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
        cmp_count++;
        if (s !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1 v = reg_rdata;
    endtask
    // Expected answer: 2 for a hit, 1 for a parity error, 0 for silence.
    task automatic cmd(input logic [7:0] b, input logic bad, input int st, input logic [7:0] e);
        hits = 0;
        irqs = 0;
        jcam_host_i.send(b, bad, st);
        chk("answer", e, 8'(hits * 2 + irqs));
        if (e == 8'h02) chk("code", {4'h0, b[7:4]}, {4'h0, cmd_code});
    endtask
    task automatic t_jumpers(input logic [15:0] v);
        logic [7:0] cb;
        logic [3:0] ad;
        cb = {<<{v[11:4]}};
        ad = {<<{v[3:0]}};
        hdr <= v;
        repeat (8) @(posedge clk);
        wr(4'h0, 8'hff);
        rd(4'h0, rdv);
        chk("cfg", cb, rdv);
        rd(4'h1, rdv);
        chk("flags", {4'h0, v[15:13], ~v[12]}, rdv);
        rd(4'h2, rdv);
        chk("addr", {4'h0, ad}, rdv);
        rd(4'h4, rdv);
        chk("query", {6'h00, v[15:14]}, rdv);
        rd(4'hf, rdv);
        chk("unmapped", 8'h00, rdv);
    endtask
    task automatic t_addr;
        logic [3:0] ad;
        ad = {<<{hdr[3:0]}};
        for (int i = 0; i < 16; i++) begin
            cmd({4'(i), ad}, 1'b0, 3, 8'h02);
            cmd({4'(15 - i), 4'(i)}, 1'b0, 8, (4'(i) == ad) ? 8'h02 : 8'h00);
        end
        cmd({4'h7, ad}, 1'b1, 3, 8'h02);
    endtask
    task automatic t_parity;
        logic [3:0] ad;
        ad = {<<{hdr[3:0]}};
        cmd({4'h3, ad}, 1'b0, 3, 8'h02);
        cmd({4'h5, ad}, 1'b1, 5, 8'h01);
        cmd({4'h5, ~ad}, 1'b1, 3, 8'h00);
    endtask
    task automatic t_head;
        for (int m = 0; m < 2; m++) begin
            wr(4'h3, 8'(m));
            rd(4'h3, rdv);
            chk("mode", 8'(m), rdv);
            for (int i = 0; i < 16; i++) begin
                head_num <= 4'(i);
                wcl_req  <= ~i[0];
                @(posedge clk);
                #1 chk("head", {5'h00, 3'(i)}, {5'h00, head_sel});
                chk("wcl", {7'h00, m[0] ? i[3] : ~i[0]}, {7'h00, wcl});
            end
        end
    endtask
    task automatic t_diag;
        int   tg;
        logic lp;
        diags = 0;
        wr(4'h3, 8'h02);
        repeat (4) @(posedge clk);
        wr(4'h3, 8'h08);
        repeat (4) @(posedge clk);
        #1 chk("runs", 8'h02, 8'(diags));
        tg = 0;
        lp = power_light;
        for (int i = 0; i < 32; i++) begin
            @(posedge clk);
            #1 tg += int'(power_light !== lp);
            lp = power_light;
        end
        chk("blink", 8'h01, {7'h00, tg inside {[7:8]}});
        wr(4'h3, 8'h04);
        repeat (3) @(posedge clk);
        tg = 0;
        for (int i = 0; i < 12; i++) begin
            @(posedge clk);
            #1 tg += int'(power_light !== 1'b0);
        end
        chk("light off", 8'h00, 8'(tg));
        rd(4'h5, rdv);
        chk("status", 8'h0a, rdv & 8'h0b);
    endtask

    initial begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        t_jumpers(16'h5a3b);
        chk("light", 8'h01, {7'h00, power_light});
        t_addr;
        t_head;
        t_jumpers(16'ha5c4);
        t_parity;
        t_diag;
        complete_run;
    end
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        complete_run;
    end
endmodule
